//--- gpio_wake_pkg.sv
// constants shared by the port and wakeup block
package gpio_wake_pkg;
  // ---------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_WAKE_EDGE_SELECT = 8'hAF;
  localparam logic [7:0] IDX_WAKE_PENDING_FLAGS = 8'hB0;
  localparam logic [7:0] IDX_WAKE_ENABLE = 8'hB1;
  localparam logic [7:0] IDX_PIN_OUTPUT_VALUE = 8'hB2;
  localparam logic [7:0] IDX_PIN_DIRECTION = 8'hB3;
  localparam logic [7:0] IDX_PIN_LEVEL = 8'hB4;
  localparam logic [7:0] IDX_TIMER_ZERO_CONTROL = 8'hB6;
  localparam logic [7:0] IDX_DEAD_DELAY_REGISTER = 8'hC0;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int TZC_WAKE_INT_EN_BIT = 7;
  localparam int TZC_TIMER_PEND_BIT = 1;
  localparam int TZC_TIMER_INT_EN_BIT = 0;
  localparam int DDR_COMP_WAKE_SEL_BIT = 6;
  localparam int COMP_CHANNEL = 6;
  localparam int PIN_ZERO = 0;
  localparam int PIN_FIVE = 5;
  // ---------------------------------------------------------------
  // reset values and sync depth
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int SYNC_STAGES = 2;
endpackage

//--- gpio_pin_sync.sv
// two-flop synchroniser for the pin inputs
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule
`default_nettype wire

//--- gpio_wake_edge.sv
// per-channel edge detector and sticky pending flags
`timescale 1ns/1ps
`default_nettype none
module gpio_wake_edge #(
  parameter int WIDTH = 8
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_sample,
  input wire logic [WIDTH-1:0] i_enable,
  input wire logic [WIDTH-1:0] i_falling_sel,
  input wire logic [WIDTH-1:0] i_clear,
  output logic [WIDTH-1:0] o_pending
);
  logic [WIDTH-1:0] prev_ff;
  logic [WIDTH-1:0] pend_ff;
  logic [WIDTH-1:0] rise;
  logic [WIDTH-1:0] fall;
  logic [WIDTH-1:0] hit;

  // compare with previous sample
  assign rise = i_sample & ~prev_ff;
  assign fall = ~i_sample & prev_ff;
  // edge choice and enable gate
  assign hit = i_enable & ((i_falling_sel & fall) | (~i_falling_sel & rise));

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_ff <= '0;
    end else begin
      prev_ff <= i_sample;
    end
  end

  // set wins over clear
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pend_ff <= '0;
    end else begin
      pend_ff <= (pend_ff & ~i_clear) | hit;
    end
  end

  assign o_pending = pend_ff;
endmodule
`default_nettype wire

//--- gpio_port_with_edge_wakeup.sv
// eight-pin port with edge wakeup unit behind an apb slave
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module gpio_port_with_edge_wakeup #(
  parameter int WIDTH = 8,
  parameter int ADDR_W = 12
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_pin,
  output logic [WIDTH-1:0] o_pin_oe,
  output logic [WIDTH-1:0] o_pin_pullup,
  // ---------------------------------------------------------------
  // nonvolatile defaults for pins zero and five: {direction, value}
  // ---------------------------------------------------------------
  input wire logic i_nv_cfg_load,
  input wire logic [1:0] i_nv_pin_zero_cfg,
  input wire logic [1:0] i_nv_pin_five_cfg,
  // ---------------------------------------------------------------
  // on-chip neighbours
  // ---------------------------------------------------------------
  input wire logic i_comparator_off_signal,
  input wire logic i_timer_overflow,
  input wire logic i_low_power_mode,
  input wire logic i_halt_idle_cmd,
  output logic o_halt_idle_enter,
  output logic o_wake_request,
  output logic o_edge_interrupt,
  output logic o_timer_interrupt
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] pin_direction_ff;
  logic [WIDTH-1:0] pin_output_value_ff;
  logic [WIDTH-1:0] wake_enable_ff;
  logic [WIDTH-1:0] wake_edge_select_ff;
  logic wake_interrupt_enable_ff;
  logic timer_pending_ff;
  logic timer_int_enable_ff;
  logic comparator_wake_select_ff;
  logic nv_done_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;

  logic [WIDTH-1:0] pin_level;
  logic [WIDTH-1:0] wake_source;
  logic [WIDTH-1:0] pend_clear;
  logic [WIDTH-1:0] wake_pending_flags;
  logic any_pending;
  logic [7:0] idx;
  logic setup_phase;
  logic wr_access;
  logic [31:0] nxt_prdata;
  logic nxt_pslverr;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic known_idx(input logic [7:0] a);
    unique case (a)
      gpio_wake_pkg::IDX_WAKE_EDGE_SELECT,
      gpio_wake_pkg::IDX_WAKE_PENDING_FLAGS,
      gpio_wake_pkg::IDX_WAKE_ENABLE,
      gpio_wake_pkg::IDX_PIN_OUTPUT_VALUE,
      gpio_wake_pkg::IDX_PIN_DIRECTION,
      gpio_wake_pkg::IDX_PIN_LEVEL,
      gpio_wake_pkg::IDX_TIMER_ZERO_CONTROL,
      gpio_wake_pkg::IDX_DEAD_DELAY_REGISTER: known_idx = 1'b1;
      default: known_idx = 1'b0;
    endcase
  endfunction

  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] target,
                                  input logic wr);
    wr_hit = wr && (a == target);
  endfunction

  assign idx = i_paddr[9:2];
  assign setup_phase = i_psel && !i_penable;
  assign wr_access = i_psel && i_penable && i_pwrite && (i_paddr[1:0] == 2'b00)
                     && (i_paddr[ADDR_W-1:10] == '0);

  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  gpio_pin_sync #(
    .WIDTH(WIDTH)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_async(i_pin),
    .o_sync(pin_level)
  );

  // ---------------------------------------------------------------
  // port configuration registers
  // ---------------------------------------------------------------
  // reset to floating inputs, then one load of pin zero/five defaults
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_direction_ff <= gpio_wake_pkg::RST_BYTE;
      nv_done_ff <= 1'b0;
    end else begin
      nv_done_ff <= 1'b1;
      if (!nv_done_ff && i_nv_cfg_load) begin
        pin_direction_ff[gpio_wake_pkg::PIN_ZERO] <= i_nv_pin_zero_cfg[1];
        pin_direction_ff[gpio_wake_pkg::PIN_FIVE] <= i_nv_pin_five_cfg[1];
      end else if (wr_hit(idx, gpio_wake_pkg::IDX_PIN_DIRECTION, wr_access)) begin
        pin_direction_ff <= i_pwdata[WIDTH-1:0];
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_output_value_ff <= gpio_wake_pkg::RST_BYTE;
    end else if (!nv_done_ff && i_nv_cfg_load) begin
      pin_output_value_ff[gpio_wake_pkg::PIN_ZERO] <= i_nv_pin_zero_cfg[0];
      pin_output_value_ff[gpio_wake_pkg::PIN_FIVE] <= i_nv_pin_five_cfg[0];
    end else if (wr_hit(idx, gpio_wake_pkg::IDX_PIN_OUTPUT_VALUE, wr_access)) begin
      pin_output_value_ff <= i_pwdata[WIDTH-1:0];
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  assign o_pin_oe = pin_direction_ff;
  assign o_pin = pin_output_value_ff & pin_direction_ff;
  assign o_pin_pullup = pin_output_value_ff & ~pin_direction_ff;

  // ---------------------------------------------------------------
  // wakeup configuration
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wake_enable_ff <= gpio_wake_pkg::RST_BYTE;
    end else if (wr_hit(idx, gpio_wake_pkg::IDX_WAKE_ENABLE, wr_access)) begin
      wake_enable_ff <= i_pwdata[WIDTH-1:0];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wake_edge_select_ff <= gpio_wake_pkg::RST_BYTE;
    end else if (wr_hit(idx, gpio_wake_pkg::IDX_WAKE_EDGE_SELECT, wr_access)) begin
      wake_edge_select_ff <= i_pwdata[WIDTH-1:0];
    end
  end

  // timer-zero control: wake enable, timer enable, timer pending
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wake_interrupt_enable_ff <= 1'b0;
      timer_int_enable_ff <= 1'b0;
    end else if (wr_hit(idx, gpio_wake_pkg::IDX_TIMER_ZERO_CONTROL, wr_access)) begin
      wake_interrupt_enable_ff <= i_pwdata[gpio_wake_pkg::TZC_WAKE_INT_EN_BIT];
      timer_int_enable_ff <= i_pwdata[gpio_wake_pkg::TZC_TIMER_INT_EN_BIT];
    end
  end

  // timer pending: overflow sets, write 0 clears, set wins
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      timer_pending_ff <= 1'b0;
    end else if (i_timer_overflow) begin
      timer_pending_ff <= 1'b1;
    end else if (wr_hit(idx, gpio_wake_pkg::IDX_TIMER_ZERO_CONTROL, wr_access)
                 && !i_pwdata[gpio_wake_pkg::TZC_TIMER_PEND_BIT]) begin
      timer_pending_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      comparator_wake_select_ff <= 1'b0;
    end else if (wr_hit(idx, gpio_wake_pkg::IDX_DEAD_DELAY_REGISTER, wr_access)) begin
      comparator_wake_select_ff <= i_pwdata[gpio_wake_pkg::DDR_COMP_WAKE_SEL_BIT];
    end
  end

  // ---------------------------------------------------------------
  // wakeup unit
  // ---------------------------------------------------------------
  // channel 6 source select; pin level used whatever the direction
  always_comb begin
    wake_source = pin_level;
    if (comparator_wake_select_ff) begin
      wake_source[gpio_wake_pkg::COMP_CHANNEL] = i_comparator_off_signal;
    end
  end

  // written zeros clear, written ones hold
  assign pend_clear = wr_hit(idx, gpio_wake_pkg::IDX_WAKE_PENDING_FLAGS, wr_access)
                      ? ~i_pwdata[WIDTH-1:0] : '0;

  gpio_wake_edge #(
    .WIDTH(WIDTH)
  ) u_edge (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_sample(wake_source),
    .i_enable(wake_enable_ff),
    .i_falling_sel(wake_edge_select_ff),
    .i_clear(pend_clear),
    .o_pending(wake_pending_flags)
  );

  assign any_pending = |wake_pending_flags;
  assign o_wake_request = any_pending && i_low_power_mode;
  assign o_edge_interrupt = any_pending && wake_interrupt_enable_ff;
  assign o_halt_idle_enter = i_halt_idle_cmd && !any_pending;
  assign o_timer_interrupt = timer_pending_ff && timer_int_enable_ff;

  // ---------------------------------------------------------------
  // apb read path, data captured in the setup cycle
  // ---------------------------------------------------------------
  always_comb begin
    nxt_prdata = 32'h00000000;
    nxt_pslverr = 1'b0;
    if (i_paddr[1:0] != 2'b00 || i_paddr[ADDR_W-1:10] != '0 || !known_idx(idx)) begin
      nxt_pslverr = 1'b1;
    end else begin
      unique case (idx)
        gpio_wake_pkg::IDX_WAKE_EDGE_SELECT: nxt_prdata[WIDTH-1:0] = wake_edge_select_ff;
        gpio_wake_pkg::IDX_WAKE_PENDING_FLAGS: nxt_prdata[WIDTH-1:0] = wake_pending_flags;
        gpio_wake_pkg::IDX_WAKE_ENABLE: nxt_prdata[WIDTH-1:0] = wake_enable_ff;
        gpio_wake_pkg::IDX_PIN_OUTPUT_VALUE: nxt_prdata[WIDTH-1:0] = pin_output_value_ff;
        gpio_wake_pkg::IDX_PIN_DIRECTION: nxt_prdata[WIDTH-1:0] = pin_direction_ff;
        gpio_wake_pkg::IDX_PIN_LEVEL: nxt_prdata[WIDTH-1:0] = pin_level;
        gpio_wake_pkg::IDX_TIMER_ZERO_CONTROL: begin
          nxt_prdata[gpio_wake_pkg::TZC_WAKE_INT_EN_BIT] = wake_interrupt_enable_ff;
          nxt_prdata[gpio_wake_pkg::TZC_TIMER_PEND_BIT] = timer_pending_ff;
          nxt_prdata[gpio_wake_pkg::TZC_TIMER_INT_EN_BIT] = timer_int_enable_ff;
        end
        default: nxt_prdata[gpio_wake_pkg::DDR_COMP_WAKE_SEL_BIT] = comparator_wake_select_ff;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else if (setup_phase) begin
      prdata_ff <= i_pwrite ? 32'h00000000 : nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign o_pready = 1'b1;
  assign o_prdata = prdata_ff;
  assign o_pslverr = pslverr_ff && i_psel && i_penable;
endmodule
`default_nettype wire

//--- gpio_wake_props.sv
// checker for the gpio port with edge wakeup
`timescale 1ns/1ps
`default_nettype none
module gpio_wake_props #(
  parameter int WIDTH = 8
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  input wire logic [WIDTH-1:0] o_pin,
  input wire logic [WIDTH-1:0] o_pin_oe,
  input wire logic [WIDTH-1:0] o_pin_pullup,
  input wire logic i_low_power_mode,
  input wire logic i_halt_idle_cmd,
  input wire logic o_halt_idle_enter,
  input wire logic o_wake_request,
  input wire logic o_edge_interrupt
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic wr;
  assign wr = i_psel && i_penable && i_pwrite;
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  a_pready_zero_wait: assert property (i_psel && i_penable |-> o_pready)
    else $error("pready low in access phase");
  a_drive_output_only: assert property ((o_pin & ~o_pin_oe) == '0)
    else $error("pin data on undriven pin");
  a_pullup_input_only: assert property ((o_pin_pullup & o_pin_oe) == '0)
    else $error("pull-up on output pin");
  // the default load for pins zero and five lands one clock after reset release
  a_oe_write_cause: assert property ($changed(o_pin_oe) |->
    $past(wr) || $past(i_rst) || $past(i_rst, 2))
    else $error("direction changed without write");
  a_prdata_held: assert property (!(i_psel && !i_penable) |=> $stable(o_prdata))
    else $error("read data moved outside setup");
  a_wake_in_halt: assert property (o_wake_request |-> i_low_power_mode)
    else $error("wake request outside halt");
  a_flags_shared: assert property (
    i_low_power_mode && !o_wake_request |-> !o_edge_interrupt)
    else $error("interrupt without pending flag");
  a_halt_refused: assert property (o_edge_interrupt |-> !o_halt_idle_enter)
    else $error("halt entered with flag pending");
  a_halt_granted: assert property (
    i_halt_idle_cmd && i_low_power_mode && !o_wake_request |-> o_halt_idle_enter)
    else $error("halt refused with no flag");
  a_irq_sticky: assert property ($fell(o_edge_interrupt) |-> $past(wr))
    else $error("interrupt dropped without write");
  a_slverr_access: assert property (o_pslverr |-> i_psel && i_penable)
    else $error("error outside access phase");
endmodule
bind gpio_port_with_edge_wakeup gpio_wake_props #(.WIDTH(WIDTH)) u_props (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
  .o_pin(o_pin), .o_pin_oe(o_pin_oe), .o_pin_pullup(o_pin_pullup),
  .i_low_power_mode(i_low_power_mode), .i_halt_idle_cmd(i_halt_idle_cmd),
  .o_halt_idle_enter(o_halt_idle_enter), .o_wake_request(o_wake_request),
  .o_edge_interrupt(o_edge_interrupt));
`default_nettype wire

//--- gpio_pin_board.sv
// board model that resolves the level of each port pin
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_board (
  input wire logic i_core_clk,
  input wire logic [7:0] i_oe,
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_pullup,
  input wire logic [7:0] i_ext_en,
  input wire logic [7:0] i_ext,
  output logic [7:0] o_level
);
  logic [7:0] float_ff = 8'h55;
  // undriven lines wander every cycle
  always @(posedge i_core_clk) begin
    float_ff <= ~float_ff;
  end
  // port drive wins, then board source, then weak pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (i_oe[i]) begin
        o_level[i] = i_out[i];
      end else if (i_ext_en[i]) begin
        o_level[i] = i_ext[i];
      end else begin
        o_level[i] = i_pullup[i] ? 1'b1 : float_ff[i];
      end
    end
  end
endmodule
`default_nettype wire

//--- gpio_port_with_edge_wakeup_tb_top.sv
// self-checking bench for the gpio port with edge wakeup
`timescale 1ns/1ps
`default_nettype none
module gpio_port_with_edge_wakeup_tb_top;
  localparam logic [7:0] ESEL = gpio_wake_pkg::IDX_WAKE_EDGE_SELECT;
  localparam logic [7:0] PEND = gpio_wake_pkg::IDX_WAKE_PENDING_FLAGS;
  localparam logic [7:0] WEN = gpio_wake_pkg::IDX_WAKE_ENABLE;
  localparam logic [7:0] VAL = gpio_wake_pkg::IDX_PIN_OUTPUT_VALUE;
  localparam logic [7:0] DIR = gpio_wake_pkg::IDX_PIN_DIRECTION;
  localparam logic [7:0] LVL = gpio_wake_pkg::IDX_PIN_LEVEL;
  localparam logic [7:0] TZC = gpio_wake_pkg::IDX_TIMER_ZERO_CONTROL;
  localparam logic [7:0] DDR = gpio_wake_pkg::IDX_DEAD_DELAY_REGISTER;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] pin, pout, poe, ppu, d, v, e;
  logic [7:0] ext_en = 8'h00;
  logic [7:0] ext = 8'h00;
  logic nv_load = 1'b1;
  logic cmp_off = 1'b0;
  logic tov = 1'b0;
  logic lpm = 1'b0;
  logic halt_cmd = 1'b0;
  logic halt_en, wake, eirq, tirq, err;
  logic [31:0] rd, s;
  logic [31:0] seed = 32'd50;
  int num_errors = 0;
  int checked = 0;
  always #5 i_core_clk = ~i_core_clk;
  gpio_port_with_edge_wakeup uut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .i_pin(pin), .o_pin(pout), .o_pin_oe(poe),
    .o_pin_pullup(ppu), .i_nv_cfg_load(nv_load), .i_nv_pin_zero_cfg(2'b11),
    .i_nv_pin_five_cfg(2'b01), .i_comparator_off_signal(cmp_off), .i_timer_overflow(tov),
    .i_low_power_mode(lpm), .i_halt_idle_cmd(halt_cmd), .o_halt_idle_enter(halt_en),
    .o_wake_request(wake), .o_edge_interrupt(eirq), .o_timer_interrupt(tirq));
  gpio_pin_board board (.i_core_clk(i_core_clk), .i_oe(poe), .i_out(pout), .i_pullup(ppu),
    .i_ext_en(ext_en), .i_ext(ext), .o_level(pin));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] exp_level(input logic [7:0] dd, vv, ee);
    return (dd & vv) | (~dd & ee);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] dat);
    @(posedge i_core_clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, dat};
    @(posedge i_core_clk);
    pen <= 1'b1;
    @(posedge i_core_clk);
    while (pready !== 1'b1) begin
      @(posedge i_core_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    #1;
  endtask
  task automatic halt_try(input logic exp);
    @(posedge i_core_clk);
    halt_cmd <= 1'b1;
    #1;
    chk(halt_en, exp);
    @(posedge i_core_clk);
    halt_cmd <= 1'b0;
    #1;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    final_report();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge i_core_clk);
    i_rst <= 1'b0;
    cyc(2);
    apb(0, DIR, 8'h00);
    chk(rd, 8'h01);
    apb(0, VAL, 8'h00);
    chk(rd, 8'h21);
    chk({poe, pout, ppu}, 24'h010120);
    for (int i = 0; i < 4; i++) begin
      apb(0, i == 0 ? ESEL : i == 1 ? PEND : i == 2 ? WEN : TZC, 8'h00);
      chk(rd, 8'h00);
    end
    $display("test reset done");
    ext_en <= 8'hFF;
    for (int i = 0; i < 8; i++) begin
      s = xs();
      d = s[7:0];
      v = s[15:8];
      e = s[23:16];
      ext <= e;
      apb(1, VAL, v);
      apb(1, DIR, d);
      chk(poe, d);
      chk(pout, d & v);
      chk(ppu, v & ~d);
      cyc(3);
      apb(0, LVL, 8'h00);
      chk(rd, exp_level(d, v, e));
      apb(0, DIR, 8'h00);
      chk(rd, d);
      apb(0, VAL, 8'h00);
      chk(rd, v);
    end
    apb(1, 8'hFF, 8'h12);
    chk(err, 1'b1);
    apb(0, 8'hFF, 8'h00);
    chk(err, 1'b1);
    chk(rd, 32'h00000000);
    $display("test port done");
    apb(1, DIR, 8'h00);
    apb(1, VAL, 8'h00);
    for (int f = 0; f < 2; f++) begin
      ext <= f ? 8'hFF : 8'h00;
      apb(1, TZC, 8'h00);
      apb(1, ESEL, f ? 8'hFF : 8'h00);
      apb(1, WEN, 8'h0F);
      cyc(3);
      apb(1, PEND, 8'h00);
      ext <= f ? 8'h00 : 8'hFF;
      cyc(4);
      apb(0, PEND, 8'h00);
      chk(rd, 8'h0F);
      chk(eirq, 1'b0);
      apb(1, TZC, 8'h80);
      chk(eirq, 1'b1);
      @(posedge i_core_clk);
      lpm <= 1'b1;
      cyc(1);
      chk(wake, 1'b1);
      halt_try(1'b0);
      apb(1, PEND, 8'hF7);
      apb(1, PEND, 8'hFF);
      chk(eirq, 1'b1);
      ext <= f ? 8'hFF : 8'h00;
      cyc(4);
      apb(0, PEND, 8'h00);
      chk(rd, 8'h07);
      apb(1, PEND, 8'h00);
      chk({eirq, wake}, 2'b00);
      halt_try(1'b1);
      @(posedge i_core_clk);
      lpm <= 1'b0;
    end
    $display("test wakeup done");
    ext <= 8'h00;
    apb(1, DDR, 8'h40);
    apb(1, ESEL, 8'h00);
    apb(1, WEN, 8'h40);
    cyc(3);
    apb(1, PEND, 8'h00);
    ext <= 8'hFF;
    cyc(4);
    apb(0, PEND, 8'h00);
    chk(rd, 8'h00);
    @(posedge i_core_clk);
    cmp_off <= 1'b1;
    cyc(3);
    apb(0, PEND, 8'h00);
    chk(rd, 8'h40);
    $display("test comparator done");
    apb(1, VAL, 8'h00);
    apb(1, DIR, 8'h01);
    apb(1, WEN, 8'h41);
    cyc(3);
    apb(1, PEND, 8'hFE);
    apb(1, VAL, 8'h01);
    cyc(4);
    apb(0, PEND, 8'h00);
    chk(rd, 8'h41);
    $display("test output edge done");
    apb(1, TZC, 8'h81);
    @(posedge i_core_clk);
    tov <= 1'b1;
    @(posedge i_core_clk);
    tov <= 1'b0;
    cyc(1);
    chk(tirq, 1'b1);
    apb(0, TZC, 8'h00);
    chk(rd, 8'h83);
    $display("test timer done");
    final_report();
  end
endmodule
`default_nettype wire
